// ---- rbac_axil.sv ----
/*
  AXI4-Lite slave for the framing block registers.
  Assumes the core answers hit and read data combinationally.
*/
`timescale 1ns/100ps
`default_nettype none
module rbac_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire rbac_pkg::rbac_addr_t s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output rbac_pkg::rbac_resp_t s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire rbac_pkg::rbac_addr_t s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output rbac_pkg::rbac_resp_t s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  rbac_reg_if.bus rif
);
  import rbac_pkg::*;
  `include "rbac_consts.svh"

  logic aw_held_r;
  logic w_held_r;
  rbac_addr_t awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // =====================================================================
  // Write path
  // Request to the core once both halves are held
  assign rif.wr_en = aw_held_r && w_held_r && !s_bvalid;
  assign rif.wr_addr = awaddr_r;
  assign rif.wr_data = wdata_r;
  assign rif.wr_strb = wstrb_r;

  // Address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end
    else if (s_bvalid && s_bready)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
    end
    else
    begin
      if (!aw_held_r && !s_bvalid)
        s_awready <= 1'b1;
      if (!w_held_r && !s_bvalid)
        s_wready <= 1'b1;
      if (s_awvalid && s_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
        s_wready <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_bvalid <= 1'b0;
      s_bresp <= `RBAC_RESP_OKAY;
    end
    else if (rif.wr_en)
    begin
      s_bvalid <= 1'b1;
      s_bresp <= rif.wr_hit ? `RBAC_RESP_OKAY : `RBAC_RESP_SLVERR;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end

  // =====================================================================
  // Read path
  assign rif.rd_addr = s_araddr;

  // Address taken, data answered next cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= `RBAC_RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rif.rd_hit ? rif.rd_data : 32'h0;
      s_rresp <= rif.rd_hit ? `RBAC_RESP_OKAY : `RBAC_RESP_SLVERR;
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
    else if (!s_rvalid)
      s_arready <= 1'b1;
  end
endmodule
`default_nettype wire

// ---- rbac_card_model.sv ----
/*
  Card-side source of received data bits for the framing block.
  Assumes the bench calls send for one frame at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module rbac_card_model (
  input wire logic aclk,
  output logic rx_start,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic rx_bit_coll,
  output logic rx_coll_in_eof,
  output logic rx_check_err,
  output logic rx_end
);
  // =====================================================
  // Quiet lines
  initial {rx_start, rx_bit_valid, rx_bit, rx_bit_coll, rx_coll_in_eof, rx_check_err, rx_end} = 7'h00;

  // One frame: start, data bits with a gap, end; no gap puts end on the last bit
  task automatic send(input int n, input logic [79:0] d, input logic [79:0] cm, input int gap,
                      input bit ce, input bit ec);
    int i;
    @(posedge aclk);
    rx_start <= 1'b1;
    @(posedge aclk);
    rx_start <= 1'b0;
    for (i = 0; i < n; i++)
    begin
      rx_bit_valid <= 1'b1;
      rx_bit <= d[i];
      rx_bit_coll <= cm[i];
      rx_check_err <= ce && (i == 0);
      rx_end <= (gap == 0) && (i == n - 1);
      rx_coll_in_eof <= ec && (gap == 0) && (i == n - 1);
      @(posedge aclk);
      if (gap > 0)
      begin
        rx_bit_valid <= 1'b0;
        rx_bit_coll <= 1'b0;
        rx_check_err <= 1'b0;
        rx_bit <= ~d[i]; // Released line, no stale bit
        repeat (gap) @(posedge aclk);
      end
    end
    {rx_bit_valid, rx_bit_coll, rx_check_err} <= 3'h0;
    rx_bit <= ~rx_bit;
    rx_end <= (gap > 0);
    rx_coll_in_eof <= ec && (gap > 0);
    @(posedge aclk);
    rx_end <= 1'b0;
    rx_coll_in_eof <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- rbac_consts.svh ----
/*
  Register indices, field positions and reset values of the receive
  bit framing block. Assumes inclusion by bare name from design files.
*/
`ifndef RBAC_CONSTS_SVH
`define RBAC_CONSTS_SVH

// =====================================================================
// Register indices and byte addresses
`define RBAC_IDX_ERR 6'h0A
`define RBAC_IDX_BITCTRL 6'h0C
`define RBAC_IDX_COLL 6'h0D
`define RBAC_ADDR_ERR ({`RBAC_IDX_ERR, 2'b00})
`define RBAC_ADDR_BITCTRL ({`RBAC_IDX_BITCTRL, 2'b00})
`define RBAC_ADDR_COLL ({`RBAC_IDX_COLL, 2'b00})

// =====================================================================
// Field positions
`define RBAC_KEEP_BIT 7
`define RBAC_ALIGN_MSB 6
`define RBAC_ALIGN_LSB 4
`define RBAC_COLLISION_AS_INTEGRITY_ERROR_BIT 3
`define RBAC_LAST_MSB 2
`define RBAC_CPV_BIT 7
`define RBAC_INTEG_BIT 0
`define RBAC_COLLISION_DETECTED_FLAG_BIT 2

// =====================================================================
// Reset values and limits
`define RBAC_BITCTRL_RST 8'h00
`define RBAC_POS_LIMIT 7'h40
`define RBAC_RESP_OKAY 2'h0
`define RBAC_RESP_SLVERR 2'h2

`endif

// ---- rbac_pkg.sv ----
/*
  Types shared by the receive bit framing block.
  Assumes nothing of its surroundings.
*/
package rbac_pkg;
  // Receive sequencing states
  typedef enum logic {RBAC_IDLE, RBAC_RECV} rbac_rx_state_t;
  typedef logic [7:0] rbac_byte_t;
  typedef logic [7:0] rbac_addr_t;
  typedef logic [1:0] rbac_resp_t;
endpackage

// ---- rbac_reg_if.sv ----
/*
  Register access carrier between the bus slave and the framing core.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface rbac_reg_if;
  import rbac_pkg::*;
  // Write request, one-cycle pulse
  logic wr_en;
  rbac_addr_t wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  // Read lookup, combinational
  rbac_addr_t rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

// ---- rbac_top.sv ----
/*
  Receive bit framing and collision reporting core with register file.
  Assumes the decoder delivers one data bit per strobe, framing bits
  already removed, and that all inputs are synchronous to aclk.
*/
// The AXI4-Lite register port was chosen for this implementation.
// Operation
// - Without keep control, bits after collision zeroed
// - First-bit position field places first stored bit
// - Position seven wraps second bit to next byte
// - Position zero byte-oriented, nonzero bit-oriented
// - Collision raises integrity error when enabled
// - Last-byte field counts valid bits, zero full
// - Last-byte field cleared at start, loaded at end only when bit-oriented
// - Position-valid set only for meaningful position
// - Position-valid zero without collision or out-of-range
// - Position counts data bits only
// - Positions reported within first eight bytes
// - Numbering zero-based, continuous across bytes
// - Position includes first-bit offset
// - Integrity error cleared at reception start
// - Collision flag set, not inside end symbol
`timescale 1ns/100ps
`default_nettype none
module rbac_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire rbac_pkg::rbac_addr_t s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output rbac_pkg::rbac_resp_t s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire rbac_pkg::rbac_addr_t s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output rbac_pkg::rbac_resp_t s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic rx_start,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_bit_coll,
  input wire logic rx_coll_in_eof,
  input wire logic rx_check_err,
  input wire logic rx_end,
  output logic store_valid,
  output rbac_pkg::rbac_byte_t store_byte,
  output logic store_last,
  output logic rx_bit_oriented,
  output logic frame_done
);
  import rbac_pkg::*;
  `include "rbac_consts.svh"

  rbac_reg_if rif ();

  rbac_rx_state_t state_r;
  logic keep_r;
  logic [2:0] align_r;
  logic collision_as_integrity_error_r;
  logic [2:0] last_r;
  logic cpv_r;
  logic [5:0] pos_r;
  logic integ_r;
  logic collision_detected_flag_r;
  logic coll_seen_r;
  logic [2:0] bitpos_r;
  logic bits_seen_r;
  rbac_byte_t asm_r;
  logic [6:0] pos_cnt_r;
  logic bit_take;
  logic end_take;
  logic coll_ev;
  logic first_coll;
  logic bit_val;
  logic wr_ctrl;
  rbac_byte_t asm_nxt;

  // =====================================================================
  // Bus slave
  rbac_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .rif(rif)
  );

  // =====================================================================
  // Register decode
  // Write hit and control write strobe
  assign rif.wr_hit = (rif.wr_addr == `RBAC_ADDR_BITCTRL) || (rif.wr_addr == `RBAC_ADDR_COLL) ||
                      (rif.wr_addr == `RBAC_ADDR_ERR);
  assign wr_ctrl = rif.wr_en && (rif.wr_addr == `RBAC_ADDR_BITCTRL) && rif.wr_strb[0];

  // Read mux, upper bits zero
  always_comb
  begin
    rif.rd_hit = 1'b1;
    rif.rd_data = 32'h0;
    case (rif.rd_addr)
      `RBAC_ADDR_BITCTRL: rif.rd_data[7:0] = {keep_r, align_r, collision_as_integrity_error_r, last_r};
      `RBAC_ADDR_COLL: rif.rd_data[7:0] = {cpv_r, 1'b0, pos_r};
      `RBAC_ADDR_ERR: rif.rd_data[7:0] = {5'h00, collision_detected_flag_r, 1'b0, integ_r};
      default: rif.rd_hit = 1'b0;
    endcase
  end

  // =====================================================================
  // Receive events
  assign bit_take = (state_r == RBAC_RECV) && rx_bit_valid;
  assign end_take = (state_r == RBAC_RECV) && rx_end;
  assign coll_ev = bit_take && rx_bit_coll;
  assign first_coll = coll_ev && !coll_seen_r;
  // Bits after the first collision forced low unless kept
  assign bit_val = (coll_seen_r && !keep_r) ? 1'b0 : rx_bit;

  // Byte under assembly with the new bit placed
  always_comb
  begin
    asm_nxt = asm_r;
    asm_nxt[bitpos_r] = bit_val;
  end

  // Reception sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= RBAC_IDLE;
    else
    begin
      case (state_r)
        RBAC_IDLE: if (rx_start) state_r <= RBAC_RECV;
        RBAC_RECV: if (rx_end && !rx_start) state_r <= RBAC_IDLE;
        default: state_r <= RBAC_IDLE;
      endcase
    end
  end

  // =====================================================================
  // Control fields written by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      keep_r <= 1'(`RBAC_BITCTRL_RST >> `RBAC_KEEP_BIT);
      align_r <= 3'h0;
      collision_as_integrity_error_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      keep_r <= rif.wr_data[`RBAC_KEEP_BIT];
      align_r <= rif.wr_data[`RBAC_ALIGN_MSB:`RBAC_ALIGN_LSB];
      collision_as_integrity_error_r <= rif.wr_data[`RBAC_COLLISION_AS_INTEGRITY_ERROR_BIT];
    end
  end

  // Orientation follows the first-bit position
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_bit_oriented <= 1'b0;
    else
      rx_bit_oriented <= (align_r != 3'h0);
  end

  // Last-byte valid bits: decoder updates win over software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      last_r <= 3'h0;
    else if (end_take && !rx_start && rx_bit_oriented)
      last_r <= bitpos_r + {2'h0, bit_take};
    else if (rx_start)
      last_r <= 3'h0;
    else if (wr_ctrl)
      last_r <= rif.wr_data[`RBAC_LAST_MSB:0];
  end

  // =====================================================================
  // Bit placement and byte output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bitpos_r <= 3'h0;
      bits_seen_r <= 1'b0;
      asm_r <= 8'h00;
      store_valid <= 1'b0;
      store_byte <= 8'h00;
      store_last <= 1'b0;
      frame_done <= 1'b0;
    end
    else
    begin
      store_valid <= 1'b0;
      store_last <= 1'b0;
      frame_done <= 1'b0;
      if (rx_start)
      begin
        bitpos_r <= align_r;
        bits_seen_r <= 1'b0;
        asm_r <= 8'h00;
      end
      else if (bit_take)
      begin
        bits_seen_r <= 1'b1;
        if (bitpos_r == 3'h7)
        begin
          // Full byte out, next bit lands on bit 0
          store_valid <= 1'b1;
          store_byte <= asm_nxt;
          store_last <= rx_end;
          asm_r <= 8'h00;
          bitpos_r <= 3'h0;
        end
        else
        begin
          asm_r <= asm_nxt;
          bitpos_r <= bitpos_r + 3'h1;
          if (rx_end)
          begin
            store_valid <= 1'b1;
            store_byte <= asm_nxt;
            store_last <= 1'b1;
          end
        end
        frame_done <= rx_end;
      end
      else if (end_take)
      begin
        // Partial final byte flushed
        if (bits_seen_r && (bitpos_r != 3'h0))
        begin
          store_valid <= 1'b1;
          store_byte <= asm_r;
          store_last <= 1'b1;
        end
        frame_done <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Collision position tracking
  // Stored bit position counter, saturating past eight bytes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pos_cnt_r <= 7'h00;
    else if (rx_start)
      pos_cnt_r <= {4'h0, align_r};
    else if (bit_take && (pos_cnt_r < `RBAC_POS_LIMIT))
      pos_cnt_r <= pos_cnt_r + 7'h01;
  end

  // First collision latch and its position
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      coll_seen_r <= 1'b0;
      cpv_r <= 1'b0;
      pos_r <= 6'h00;
    end
    else if (first_coll && !rx_start)
    begin
      coll_seen_r <= 1'b1;
      cpv_r <= (pos_cnt_r < `RBAC_POS_LIMIT);
      pos_r <= (pos_cnt_r < `RBAC_POS_LIMIT) ? pos_cnt_r[5:0] : 6'h00;
    end
    else if (rx_start)
    begin
      coll_seen_r <= 1'b0;
      cpv_r <= 1'b0;
      pos_r <= 6'h00;
    end
  end

  // =====================================================================
  // Error flags: a set in the start cycle wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      integ_r <= 1'b0;
    else if ((state_r == RBAC_RECV && rx_check_err) || (coll_ev && collision_as_integrity_error_r))
      integ_r <= 1'b1;
    else if (rx_start)
      integ_r <= 1'b0;
  end

  // Collision flag, end-symbol collisions come on their own input
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      collision_detected_flag_r <= 1'b0;
    else if (coll_ev)
      collision_detected_flag_r <= 1'b1;
    else if (rx_start)
      collision_detected_flag_r <= 1'b0;
  end

  // =====================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_quiet_bit;
    bit_take && !rx_start && !rx_end;
  endsequence

  sequence s_first_coll;
    first_coll && !rx_start;
  endsequence

  a_zero_after_coll: assert property (s_quiet_bit and (coll_seen_r && !keep_r && bitpos_r != 3'h7)
    |=> asm_r[$past(bitpos_r)] == 1'b0)
    else $error("bit after collision not zeroed");
  a_align_load: assert property (rx_start ##1 (s_quiet_bit and (bitpos_r != 3'h7))
    |=> asm_r[$past(align_r, 2)] == $past(rx_bit))
    else $error("first bit not at aligned position");
  a_wrap_next: assert property (s_quiet_bit and (bitpos_r == 3'h7) |=> store_valid && bitpos_r == 3'h0)
    else $error("no wrap after bit seven");
  a_orient_mode: assert property (##1 rx_bit_oriented == ($past(align_r) != 3'h0))
    else $error("orientation wrong");
  a_coll_integ: assert property (coll_ev && collision_as_integrity_error_r |=> integ_r)
    else $error("collision did not raise integrity error");
  a_last_clear: assert property (rx_start |=> last_r == 3'h0)
    else $error("last bits not cleared at start");
  a_last_load: assert property (end_take && !rx_start && rx_bit_oriented
    |=> last_r == $past(bitpos_r) + {2'h0, $past(bit_take)})
    else $error("last bits not loaded at end");
  a_pos_record: assert property (s_first_coll and (pos_cnt_r < `RBAC_POS_LIMIT)
    |=> cpv_r && pos_r == $past(pos_cnt_r[5:0]))
    else $error("collision position wrong");
  a_pos_range: assert property (s_first_coll and (pos_cnt_r >= `RBAC_POS_LIMIT) |=> !cpv_r)
    else $error("valid set out of range");
  a_valid_cause: assert property ($rose(cpv_r) |-> $past(first_coll))
    else $error("valid set without collision");
  a_start_clear: assert property (rx_start && !coll_ev && !rx_check_err |=> !integ_r && !cpv_r && !collision_detected_flag_r)
    else $error("flags not cleared at start");
  a_pos_hold: assert property (coll_ev && coll_seen_r && !rx_start |=> $stable(pos_r) && $stable(cpv_r))
    else $error("later collision moved position");
  a_eof_coll: assert property (rx_coll_in_eof && !coll_ev && !collision_detected_flag_r |=> !collision_detected_flag_r)
    else $error("end symbol collision flagged");
  a_start_pos: assert property (rx_start |=> pos_cnt_r == {4'h0, $past(align_r)} ##0 !coll_seen_r)
    else $error("position tracking not reset");
endmodule
`default_nettype wire

// ---- rx_bit_align_collision_tb.sv ----
/*
  Self-checking bench: AXI4-Lite register tasks and card frames.
  Assumes the design files and the card model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rbac_consts.svh"
module rx_bit_align_collision_tb;
  import rbac_pkg::*;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, store_valid, store_last, rx_bit_oriented, frame_done;
  logic rx_start, rx_bit_valid, rx_bit, rx_bit_coll, rx_coll_in_eof, rx_check_err, rx_end;
  rbac_addr_t s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  rbac_resp_t s_bresp, s_rresp;
  rbac_byte_t store_byte;
  logic [8:0] q [$];
  int mismatches = 0;
  int n_checks = 0;

  // =====================================================
  // Clock, design and card
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  rbac_top dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .rx_start, .rx_bit_valid, .rx_bit, .rx_bit_coll, .rx_coll_in_eof,
    .rx_check_err, .rx_end, .store_valid, .store_byte, .store_last, .rx_bit_oriented, .frame_done);
  rbac_card_model card (.aclk, .rx_start, .rx_bit_valid, .rx_bit, .rx_bit_coll, .rx_coll_in_eof,
    .rx_check_err, .rx_end);

  // Collect stored bytes with their last marker
  always @(posedge aclk)
    if (store_valid === 1'b1)
      q.push_back({store_last, store_byte});

  // =====================================================
  // Checking and closing
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task give_up();
    mismatches++;
    $display("BAD %0t got %h exp %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask

  // =====================================================
  // Bus tasks
  task wr(input rbac_addr_t a, input logic [31:0] d, input logic [3:0] st, output rbac_resp_t r);
    int k;
    bit ad;
    bit wd;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= st;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    ad = 0;
    wd = 0;
    for (k = 0; k < 50 && !(ad && wd); k++)
    begin
      @(posedge aclk);
      if (!ad && s_awready === 1'b1)
        s_awvalid <= 1'b0;
      if (!wd && s_wready === 1'b1)
        s_wvalid <= 1'b0;
      ad = ad | (s_awready === 1'b1);
      wd = wd | (s_wready === 1'b1);
    end
    if (!(ad && wd))
      give_up();
    for (k = 0; k < 50 && s_bvalid !== 1'b1; k++)
      @(posedge aclk);
    if (k == 50)
      give_up();
    r = s_bresp;
    s_bready <= 1'b0;
  endtask

  task rd(input rbac_addr_t a, output logic [31:0] d, output rbac_resp_t r);
    int k;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    k = 0;
    // Let the raised request stand at least one edge before looking for ready
    do
    begin
      @(posedge aclk);
      k++;
    end
    while (s_arready !== 1'b1 && k < 50);
    if (s_arready !== 1'b1)
      give_up();
    s_arvalid <= 1'b0;
    for (k = 0; k < 50 && s_rvalid !== 1'b1; k++)
      @(posedge aclk);
    if (k == 50)
      give_up();
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask

  task rchk(input rbac_addr_t a, input logic [31:0] exp);
    logic [31:0] d;
    rbac_resp_t r;
    rd(a, d, r);
    chk(d, exp);
    chk(r, `RBAC_RESP_OKAY);
  endtask

  // One frame from the card, then bytes and registers against the model
  task frame(input logic [7:0] ctl, input int n, input logic [79:0] d, input logic [79:0] cm,
             input int gap, input bit ce, input bit ec);
    logic [7:0] eb [0:10];
    int i, p, fc, al, nb;
    rbac_resp_t r;
    al = ctl[6:4];
    fc = -1;
    wr(`RBAC_ADDR_BITCTRL, {24'h0, ctl}, 4'h1, r);
    q.delete();
    card.send(n, d, cm, gap, ce, ec);
    for (i = 0; i < 20 && frame_done !== 1'b1; i++)
      @(posedge aclk);
    if (i == 20)
      give_up();
    @(posedge aclk);
    for (i = 0; i < 11; i++)
      eb[i] = 8'h00;
    for (i = n - 1; i >= 0; i--)
      if (cm[i])
        fc = i;
    for (i = 0; i < n; i++)
    begin
      p = al + i;
      eb[p / 8][p % 8] = d[i] & (ctl[7] || fc < 0 || i <= fc);
    end
    nb = (al + n + 7) / 8;
    chk(q.size(), nb);
    for (i = 0; i < nb && i < q.size(); i++)
      chk(q[i][7:0], eb[i]);
    if (q.size() == nb && (al + n) % 8 != 0)
      chk(q[nb - 1][8], 1'b1);
    chk(rx_bit_oriented, al != 0);
    rchk(`RBAC_ADDR_BITCTRL, {ctl[7:3], (al != 0) ? 3'((al + n) % 8) : 3'h0});
    rchk(`RBAC_ADDR_COLL, (fc >= 0 && al + fc < 64) ? 8'h80 | 8'(al + fc) : 8'h00);
    rchk(`RBAC_ADDR_ERR, {fc >= 0, 1'b0, ce || (ctl[3] && fc >= 0)});
  endtask

  // =====================================================
  // Main sequence
  initial
  begin
    logic [31:0] d;
    rbac_resp_t r;
    int a;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, aresetn} = 6'h00;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = 52'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`RBAC_ADDR_BITCTRL, {24'h0, `RBAC_BITCTRL_RST});
    rchk(`RBAC_ADDR_COLL, 32'h0);
    rchk(`RBAC_ADDR_ERR, 32'h0);
    rd(8'h3C, d, r);
    chk(d, 32'h0);
    chk(r, `RBAC_RESP_SLVERR);
    wr(8'h3C, 32'hFF, 4'hF, r);
    chk(r, `RBAC_RESP_SLVERR);
    wr(`RBAC_ADDR_BITCTRL, 32'hB8, 4'hF, r);
    rchk(`RBAC_ADDR_BITCTRL, 32'hB8);
    wr(`RBAC_ADDR_BITCTRL, 32'h00, 4'h0, r);
    rchk(`RBAC_ADDR_BITCTRL, 32'hB8);
    wr(`RBAC_ADDR_COLL, 32'hFF, 4'hF, r);
    chk(r, `RBAC_RESP_OKAY);
    rchk(`RBAC_ADDR_COLL, 32'h0);
    chk(rx_bit_oriented, 1'b1);
    $display("test registers done");
    // Every first-bit position with one collided bit
    for (a = 0; a < 8; a++)
      frame({1'b1, 3'(a), 4'h0}, 11, 80'h5A3, 80'h4, 0, 0, 0);
    $display("test alignment done");
    frame(8'h00, 24, 80'hF0F0F0, 80'h1200, 0, 0, 0);
    frame(8'h80, 24, 80'hF0F0F0, 80'h1200, 1, 0, 0);
    frame(8'h48, 4, 80'hF, 80'h8, 2, 0, 0);
    frame(8'h70, 3, 80'h5, 80'h0, 3, 0, 0);
    $display("test placement done");
    // Edge of the reportable range, then clearing at each start
    frame(8'h08, 72, 80'hA5A55A5AC3C33C3C, 80'h1 << 63, 0, 0, 0);
    frame(8'h08, 72, 80'hA5A55A5AC3C33C3C, 80'h1 << 64, 0, 0, 0);
    frame(8'h10, 5, 80'h15, 80'h0, 0, 1, 1);
    frame(8'h00, 16, 80'h1234, 80'h0, 0, 0, 0);
    $display("test range done");
    complete_run();
  end
endmodule
`default_nettype wire
